// [core/tgp_gate_timer.sv]
// Notes on behaviour
// - Two-bit field selects one of four gate sources
// - Polarity bit 6 applied to selected source
// - Match wrap gives one-instruction-cycle gate pulse
// - Match source: polarity picks cycle after match
// - Comparator sources use status bits 5, 6
// - Toggle flip-flop flips on incrementing edges
// - Bit 5 enables toggle; clear holds flop clear
// - Single-pulse armed by bits 4 and 3
// - Trailing edge clears go/done; then ignore gate
// - Clearing single-pulse enable clears go/done
// - Toggle plus single-pulse counts one full period
// - Bit 2 shows live gate level always
// - Period timer counts instruction clocks upward
// - Compare each cycle; match resets, clocks postscaler
// - Reset clears count, period loads FFh
// - Count or control write clears pre/postscalers
// - Control write keeps timer count
// - Postscale ratio is field plus one
// - Timer runs only while on bit set
// - Count and period readable and writable
// - Postscaler sets flag; enable gates interrupt
// - Gated counter increments while gate active; with enable bit 7 clear, on every tick
//
// Chosen here: the Avalon-MM register port and the register offsets.
module tgp_gate_timer #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock, reset, enable
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     clk_en,
  // Avalon-MM slave
  input  wire logic [5:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // Gate sources
  input  wire logic                     gate_input_pin,
  input  wire logic [7:0]               comparator_status,
  // Counter clock tick and results
  input  wire logic                     counter_tick,
  output logic      [COUNT_WIDTH-1:0]   gated_counter,
  output logic                          period_match,
  output logic                          period_match_irq
);
  import tgp_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  tgp_gate_cfg_t          gate_cfg_reg;
  tgp_timer_cfg_t         timer_cfg_reg;
  logic [7:0]             count_reg;
  logic [7:0]             period_reg;
  logic [1:0]             iclk_reg;
  logic [3:0]             pre_reg;
  logic [3:0]             post_reg;
  logic                   flag_reg;
  logic                   irq_en_reg;
  logic                   wrap_reg;
  logic [2:0]             sync1_reg;
  logic [2:0]             sync2_reg;
  logic                   src_prev_reg;
  logic                   tog_reg;
  logic                   gate_prev_reg;
  logic                   armed_reg;
  logic                   ack_reg;
  logic [COUNT_WIDTH-1:0] gcount_reg;

  logic       wr_go;
  logic       rd_go;
  logic [3:0] idx;
  logic       wr_gate;
  logic       wr_count;
  logic       wr_period;
  logic       wr_tctrl;
  logic       wr_gcount;
  logic       wr_irq;
  logic       iclk;
  logic       pre_hit;
  logic       step;
  logic       match;
  logic       post_hit;
  logic       src_raw;
  logic       src_pol;
  logic       src_rise;
  logic       toggled;
  logic       gate_level;
  logic       gate_fall;
  logic [3:0] pre_limit;
  logic       count_en;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction

  assign idx       = avs_address[5:2];
  assign wr_go     = avs_write && ack_reg && avs_byteenable[0] && clk_en;
  assign rd_go     = avs_read && !ack_reg && clk_en;
  assign wr_gate   = wr_go && hit(idx, TGP_IDX_GATE_CONTROL);
  assign wr_count  = wr_go && hit(idx, TGP_IDX_TIMER_COUNT);
  assign wr_period = wr_go && hit(idx, TGP_IDX_PERIOD_VALUE);
  assign wr_tctrl  = wr_go && hit(idx, TGP_IDX_TIMER_CONTROL);
  assign wr_gcount = wr_go && hit(idx, TGP_IDX_GATED_COUNT);
  assign wr_irq    = wr_go && hit(idx, TGP_IDX_IRQ_CONTROL);

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // One wait cycle; write lands on the answer edge
  assign avs_waitrequest = (avs_read || avs_write) && !(ack_reg && clk_en);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0;
    end else if (rd_go) begin
      case (idx)
        TGP_IDX_GATE_CONTROL:
          avs_readdata <= {24'h0, gate_cfg_reg[6:2], gate_level,
                           gate_cfg_reg.source};
        TGP_IDX_TIMER_COUNT:   avs_readdata <= {24'h0, count_reg};
        TGP_IDX_PERIOD_VALUE:  avs_readdata <= {24'h0, period_reg};
        TGP_IDX_TIMER_CONTROL: avs_readdata <= {25'h0, timer_cfg_reg};
        TGP_IDX_GATED_COUNT:
          avs_readdata <= 32'(gcount_reg);
        TGP_IDX_IRQ_CONTROL:
          avs_readdata <= {30'h0, flag_reg, irq_en_reg};
        default:               avs_readdata <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Period timer
  // ---------------------------------------------------------------
  assign iclk      = (iclk_reg == TGP_ICLK_DIV);
  always_comb begin
    case (timer_cfg_reg.prescale)
      2'h0:    pre_limit = '0;
      2'h1:    pre_limit = TGP_PRE_DIV4;
      default: pre_limit = TGP_PRE_DIV16;
    endcase
  end
  assign pre_hit   = (pre_reg >= pre_limit);
  assign step      = clk_en && iclk && timer_cfg_reg.on && pre_hit;
  assign match     = (count_reg == period_reg);
  assign post_hit  = step && match &&
                     (post_reg >= timer_cfg_reg.postscale);
  assign period_match = match;

  // ----------------------------------------
  // Prescaler, postscaler and count
  // ----------------------------------------

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      iclk_reg <= 2'h0;
    end else if (clk_en) begin
      iclk_reg <= iclk_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_cfg_reg <= '0;
    end else if (wr_tctrl) begin
      timer_cfg_reg <= tgp_timer_cfg_t'(avs_writedata[6:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= 4'h0;
    end else if (wr_count || wr_tctrl) begin
      pre_reg <= 4'h0;
    end else if (clk_en && iclk && timer_cfg_reg.on) begin
      pre_reg <= pre_hit ? 4'h0 : pre_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      post_reg <= 4'h0;
    end else if (wr_count || wr_tctrl) begin
      post_reg <= 4'h0;
    end else if (step && match) begin
      post_reg <= post_hit ? 4'h0 : post_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= TGP_COUNT_RESET;
    end else if (wr_count) begin
      count_reg <= avs_writedata[7:0];
    end else if (step) begin
      count_reg <= match ? TGP_COUNT_RESET : count_reg + 8'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      period_reg <= TGP_PERIOD_RESET;
    end else if (wr_period) begin
      period_reg <= avs_writedata[7:0];
    end
  end

  // Wrap pulse, one instruction cycle long
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrap_reg <= 1'b0;
    end else if (clk_en && iclk) begin
      wrap_reg <= step && match;
    end
  end

  // ----------------------------------------
  // Interrupt flag
  // ----------------------------------------

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_reg <= 1'b0;
    end else if (wr_irq) begin
      irq_en_reg <= avs_writedata[TGP_IC_ENABLE];
    end
  end

  // Set wins over a software clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else if (post_hit) begin
      flag_reg <= 1'b1;
    end else if (wr_irq) begin
      flag_reg <= avs_writedata[TGP_IC_FLAG];
    end
  end

  assign period_match_irq = flag_reg && irq_en_reg;

  // ---------------------------------------------------------------
  // Gate logic
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else if (clk_en) begin
      sync1_reg <= {comparator_status[TGP_CMP2_BIT],
                    comparator_status[TGP_CMP1_BIT], gate_input_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Source select and polarity
  // ----------------------------------------

  always_comb begin
    case (gate_cfg_reg.source)
      TGP_SRC_PIN:   src_raw = sync2_reg[0];
      TGP_SRC_MATCH: src_raw = wrap_reg;
      TGP_SRC_CMP1:  src_raw = sync2_reg[1];
      TGP_SRC_CMP2:  src_raw = sync2_reg[2];
      default:       src_raw = 1'b0;
    endcase
  end

  // Active level is high after polarity: matches for match source
  assign src_pol  = src_raw ~^ gate_cfg_reg.polarity;
  assign src_rise = src_pol && !src_prev_reg;
  assign toggled  = gate_cfg_reg.toggle ? tog_reg : src_pol;
  assign gate_level = gate_cfg_reg.single_pulse ?
                      (armed_reg && toggled) : toggled;
  assign gate_fall  = gate_prev_reg && !gate_level;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_reg <= 1'b0;
    end else if (clk_en) begin
      src_prev_reg <= src_pol;
    end
  end

  // ----------------------------------------
  // Toggle flip-flop and single pulse
  // ----------------------------------------

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tog_reg <= 1'b0;
    end else if (clk_en) begin
      if (!gate_cfg_reg.toggle) begin
        tog_reg <= 1'b0;
      end else if (src_rise) begin
        tog_reg <= !tog_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gate_prev_reg <= 1'b0;
    end else if (clk_en) begin
      gate_prev_reg <= gate_level;
    end
  end

  // Armed from next incrementing edge while go is set
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (!gate_cfg_reg.go_done) begin
        armed_reg <= 1'b0;
      end else if (!armed_reg && !toggled) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Gate configuration register
  // ----------------------------------------

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gate_cfg_reg <= '0;
    end else if (wr_gate) begin
      gate_cfg_reg.enable       <= avs_writedata[TGP_GC_ENABLE];
      gate_cfg_reg.polarity     <= avs_writedata[TGP_GC_POL];
      gate_cfg_reg.toggle       <= avs_writedata[TGP_GC_TOGGLE];
      gate_cfg_reg.single_pulse <= avs_writedata[TGP_GC_SPM];
      gate_cfg_reg.go_done      <= avs_writedata[TGP_GC_SPM] &&
                                   avs_writedata[TGP_GC_GO];
      gate_cfg_reg.source       <= avs_writedata[TGP_GC_SS_LO +: 2];
    end else if (clk_en && gate_cfg_reg.single_pulse && armed_reg &&
                 gate_fall) begin
      gate_cfg_reg.go_done <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Gated counter
  // ---------------------------------------------------------------
  assign count_en = clk_en && counter_tick &&
                    (!gate_cfg_reg.enable || gate_level);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gcount_reg <= '0;
    end else if (wr_gcount) begin
      gcount_reg <= avs_writedata[COUNT_WIDTH-1:0];
    end else if (count_en) begin
      gcount_reg <= gcount_reg + COUNT_WIDTH'(1);
    end
  end

  assign gated_counter = gcount_reg;
endmodule

// [shared/tgp_pkg.sv]
package tgp_pkg;

  // ---------------------------------------------------------------
  // Register word addresses (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [3:0] TGP_IDX_GATE_CONTROL   = 4'h0;
  localparam logic [3:0] TGP_IDX_TIMER_COUNT    = 4'h1;
  localparam logic [3:0] TGP_IDX_PERIOD_VALUE   = 4'h2;
  localparam logic [3:0] TGP_IDX_TIMER_CONTROL  = 4'h3;
  localparam logic [3:0] TGP_IDX_GATED_COUNT    = 4'h4;
  localparam logic [3:0] TGP_IDX_IRQ_CONTROL    = 4'h5;

  // ---------------------------------------------------------------
  // Gate control fields
  // ---------------------------------------------------------------
  localparam int TGP_GC_ENABLE  = 7;
  localparam int TGP_GC_POL     = 6;
  localparam int TGP_GC_TOGGLE  = 5;
  localparam int TGP_GC_SPM     = 4;
  localparam int TGP_GC_GO      = 3;
  localparam int TGP_GC_VAL     = 2;
  localparam int TGP_GC_SS_LO   = 0;

  localparam logic [1:0] TGP_SRC_PIN   = 2'h0;
  localparam logic [1:0] TGP_SRC_MATCH = 2'h1;
  localparam logic [1:0] TGP_SRC_CMP1  = 2'h2;
  localparam logic [1:0] TGP_SRC_CMP2  = 2'h3;

  // Comparator status register bits
  localparam int TGP_CMP1_BIT = 5;
  localparam int TGP_CMP2_BIT = 6;

  // ---------------------------------------------------------------
  // Period timer control fields
  // ---------------------------------------------------------------
  localparam int TGP_TC_POST_LO = 3;
  localparam int TGP_TC_ON      = 2;
  localparam int TGP_TC_PRE_LO  = 0;
  localparam logic [7:0] TGP_TC_MASK = 8'h7f;

  // Interrupt control register fields
  localparam int TGP_IC_ENABLE = 0;
  localparam int TGP_IC_FLAG   = 1;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] TGP_PERIOD_RESET = 8'hff;
  localparam logic [7:0] TGP_COUNT_RESET  = 8'h00;
  localparam logic [1:0] TGP_ICLK_DIV     = 2'h3;
  localparam logic [3:0] TGP_PRE_DIV4     = 4'h3;
  localparam logic [3:0] TGP_PRE_DIV16    = 4'hf;
  localparam int         TGP_CLK_MHZ      = 125;

  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic       toggle;
    logic       single_pulse;
    logic       go_done;
    logic [1:0] source;
  } tgp_gate_cfg_t;

  typedef struct packed {
    logic [3:0] postscale;
    logic       on;
    logic [1:0] prescale;
  } tgp_timer_cfg_t;

endpackage

// [bench/tgp_gate_partner.sv]
module tgp_gate_partner (
  // Levels from the bench
  input  wire logic       clk_sys,
  input  wire logic       pin_lvl,
  input  wire logic       cmp1_lvl,
  input  wire logic       cmp2_lvl,
  input  wire logic       tick_en,
  // Toward the block
  output logic            gate_input_pin = 1'b0,
  output logic [7:0]      comparator_status = 8'h00,
  output logic            counter_tick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Gate sources, counter clock
  // ----------------------------------------
  logic [7:0] junk = 8'h5a;
  // Unused status bits keep moving
  always @(posedge clk_sys) begin
    junk <= junk + 8'h01;
    gate_input_pin <= pin_lvl;
    comparator_status <= {junk[7], cmp2_lvl, cmp1_lvl, junk[4:0]};
    counter_tick <= tick_en & ~counter_tick;
  end
endmodule

// [bench/tgp_gate_timer_props.sv]
module tgp_gate_timer_props #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock, reset, enable
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  // Bus
  input wire logic [5:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // Gate and results
  input wire logic                   gate_input_pin,
  input wire logic [7:0]             comparator_status,
  input wire logic                   counter_tick,
  input wire logic [COUNT_WIDTH-1:0] gated_counter,
  input wire logic                   period_match,
  input wire logic                   period_match_irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  sequence s_quiet4;
    (clk_en && !avs_write)[*4];
  endsequence
  a_wait_once: assert property (s_req ##1 clk_en |-> !avs_waitrequest)
    else $error("Bus wait lasted more than one cycle");
  a_wait_first: assert property ($rose(avs_read) || $rose(avs_write)
    |-> avs_waitrequest) else $error("Bus answered with no wait");
  a_read_hole: assert property (avs_read && !avs_waitrequest
    && avs_address[5:2] > 4'h5 |-> avs_readdata == 32'h0)
    else $error("Unmapped read not zero");
  a_ctrl_msb: assert property (avs_read && !avs_waitrequest
    && avs_address[5:2] == 4'h3 |-> avs_readdata[31:7] == 25'h0)
    else $error("Timer control upper bits not zero");
  a_count_step: assert property (!$past(avs_write)
    && gated_counter != $past(gated_counter) |-> $past(counter_tick)
    && gated_counter == $past(gated_counter) + 1'b1)
    else $error("Gated counter moved without a tick");
  a_freeze_all: assert property (!clk_en |=> $stable(gated_counter)
    && $stable(period_match) && $stable(period_match_irq))
    else $error("State moved while clock enable low");
  a_match_hold: assert property (($rose(period_match)
    && !$past(avs_write)) ##0 s_quiet4 |-> period_match
    && $past(period_match) && $past(period_match, 2))
    else $error("Match shorter than one instruction cycle");
  a_irq_cause: assert property ($rose(period_match_irq)
    |-> $past(avs_write) || $past(period_match) || $past(period_match, 2))
    else $error("Interrupt rose without a match");
  a_irq_fall: assert property ($fell(period_match_irq)
    |-> $past(avs_write)) else $error("Interrupt fell without a write");
  a_reset_out: assert property ($rose(reset_n) |-> gated_counter == '0
    && !period_match_irq && !period_match)
    else $error("Outputs wrong after reset");
endmodule

bind tgp_gate_timer tgp_gate_timer_props #(.COUNT_WIDTH(COUNT_WIDTH)) i_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .gate_input_pin(gate_input_pin), .comparator_status(comparator_status),
  .counter_tick(counter_tick), .gated_counter(gated_counter),
  .period_match(period_match), .period_match_irq(period_match_irq)
);

// [bench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tgp_pkg::*;
  // ----------------------------------------
  // Signals, clock, instances
  // ----------------------------------------
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd, c0, c1;
  logic        avs_waitrequest, period_match, period_match_irq;
  logic        gate_input_pin, counter_tick, p, pol, s, lvl;
  logic [7:0]  comparator_status;
  logic [15:0] gated_counter;
  logic        pin_lvl = 1'b0;
  logic        cmp1_lvl = 1'b0;
  logic        cmp2_lvl = 1'b0;
  logic        tick_en = 1'b0;
  logic [1:0]  src;
  logic [3:0]  posts [3] = '{4'h0, 4'h2, 4'hf};
  int          failures = 0;
  int          num_checks = 0;
  int          i, k, n;
  always #4 clk_sys = ~clk_sys;
  tgp_gate_timer #(.COUNT_WIDTH(16)) i_tgp_gate_timer (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gate_input_pin(gate_input_pin), .comparator_status(comparator_status),
    .counter_tick(counter_tick), .gated_counter(gated_counter),
    .period_match(period_match), .period_match_irq(period_match_irq)
  );
  tgp_gate_partner i_tgp_gate_partner (
    .clk_sys(clk_sys), .pin_lvl(pin_lvl), .cmp1_lvl(cmp1_lvl),
    .cmp2_lvl(cmp2_lvl), .tick_en(tick_en), .gate_input_pin(gate_input_pin),
    .comparator_status(comparator_status), .counter_tick(counter_tick)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int w;
    @(posedge clk_sys);
    avs_address <= {idx, 2'h0};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    w = 0;
    do begin
      @(posedge clk_sys);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 64);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w >= 64) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [3:0] idx,
                     input logic [31:0] e);
    bus(1'b0, idx, 8'h0, rd);
    chk(nm, e, rd);
  endtask
  task automatic pulse(input int c);
    pin_lvl <= 1'b1;
    repeat (c) @(posedge clk_sys);
    pin_lvl <= 1'b0;
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic wait_rise(output int c);
    logic q;
    q = period_match;
    for (c = 1; c < 4000; c++) begin
      @(posedge clk_sys);
      if (period_match === 1'b1 && q === 1'b0)
        break;
      q = period_match;
    end
    if (c >= 4000) begin
      failures++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc("period_value", TGP_IDX_PERIOD_VALUE, 32'hff);
    rdc("timer_count", TGP_IDX_TIMER_COUNT, 32'h0);
    rdc("timer_control", TGP_IDX_TIMER_CONTROL, 32'h0);
    rdc("unmapped", 4'hf, 32'h0);
    wr(TGP_IDX_TIMER_COUNT, 8'h33);
    wr(TGP_IDX_PERIOD_VALUE, 8'h5a);
    avs_byteenable <= 4'h0;
    wr(TGP_IDX_PERIOD_VALUE, 8'h11);
    avs_byteenable <= 4'hf;
    rdc("period_value", TGP_IDX_PERIOD_VALUE, 32'h5a);
    rdc("timer_count", TGP_IDX_TIMER_COUNT, 32'h33);
    wr(TGP_IDX_TIMER_CONTROL, 8'hfb);
    rdc("timer_control", TGP_IDX_TIMER_CONTROL, 32'h7b);
    rdc("count_kept", TGP_IDX_TIMER_COUNT, 32'h33);
    repeat (40) @(posedge clk_sys);
    rdc("count_off", TGP_IDX_TIMER_COUNT, 32'h33);
    $display("test registers done");
    wr(TGP_IDX_TIMER_COUNT, 8'h00);
    wr(TGP_IDX_PERIOD_VALUE, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr(TGP_IDX_TIMER_CONTROL, {5'h0, 1'b1, i[1:0]});
      wait_rise(n);
      wait_rise(n);
      chk("match_gap", (i == 0) ? 16 : (i == 1) ? 64 : 256, n);
    end
    for (i = 0; i < 3; i++) begin
      wr(TGP_IDX_TIMER_CONTROL, 8'h00);
      wr(TGP_IDX_TIMER_COUNT, 8'h00);
      wr(TGP_IDX_IRQ_CONTROL, 8'h01);
      wr(TGP_IDX_TIMER_CONTROL, {1'b0, posts[i], 1'b1, 2'h0});
      n = 0;
      p = 1'b0;
      for (k = 0; k < 6000 && period_match_irq !== 1'b1; k++) begin
        @(posedge clk_sys);
        if (period_match === 1'b1 && p === 1'b0)
          n++;
        p = period_match;
      end
      chk("post_matches", posts[i] + 32'h1, n);
      chk("post_irq", 32'h1, {31'h0, period_match_irq});
    end
    wr(TGP_IDX_IRQ_CONTROL, 8'h00);
    repeat (300) @(posedge clk_sys);
    chk("irq_masked", 32'h0, {31'h0, period_match_irq});
    rdc("irq_flag", TGP_IDX_IRQ_CONTROL, 32'h2);
    wr(TGP_IDX_TIMER_CONTROL, 8'h00);
    $display("test period timer done");
    for (k = 0; k < 16; k++) begin
      src = k[1:0];
      pol = k[2];
      s = k[3];
      pin_lvl <= (src == 2'h0) ? s : ~s;
      cmp1_lvl <= (src == 2'h2) ? s : ~s;
      cmp2_lvl <= (src == 2'h3) ? s : ~s;
      lvl = (src == 2'h1) ? 1'b0 : s;
      wr(TGP_IDX_GATE_CONTROL, {1'b0, pol, 4'h0, src});
      repeat (6) @(posedge clk_sys);
      bus(1'b0, TGP_IDX_GATE_CONTROL, 8'h0, rd);
      chk("gate_level", {31'h0, lvl == pol}, {31'h0, rd[2]});
    end
    $display("test gate sources done");
    tick_en <= 1'b1;
    pin_lvl <= 1'b0;
    wr(TGP_IDX_GATE_CONTROL, 8'hc0);
    repeat (8) @(posedge clk_sys);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, c0);
    repeat (20) @(posedge clk_sys);
    rdc("count_hold", TGP_IDX_GATED_COUNT, c0);
    chk("count_port", c0, {16'h0, gated_counter});
    pin_lvl <= 1'b1;
    clk_en <= 1'b0;
    repeat (10) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (20) @(posedge clk_sys);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, rd);
    chk("count_runs", 32'h1, {31'h0, rd[15:0] > c0[15:0]});
    pin_lvl <= 1'b0;
    wr(TGP_IDX_GATE_CONTROL, 8'he0);
    pulse(6);
    rdc("toggle_on", TGP_IDX_GATE_CONTROL, 32'he4);
    pulse(6);
    rdc("toggle_off", TGP_IDX_GATE_CONTROL, 32'he0);
    pulse(6);
    wr(TGP_IDX_GATE_CONTROL, 8'hc0);
    rdc("toggle_clear", TGP_IDX_GATE_CONTROL, 32'hc0);
    wr(TGP_IDX_GATE_CONTROL, 8'he0);
    rdc("toggle_held", TGP_IDX_GATE_CONTROL, 32'he0);
    wr(TGP_IDX_TIMER_CONTROL, 8'h04);
    for (i = 0; i < 2; i++) begin
      wr(TGP_IDX_GATE_CONTROL, {1'b1, i[0], 6'h01});
      wait_rise(n);
      c0 = {16'h0, gated_counter};
      wait_rise(n);
      c1 = {16'h0, gated_counter} - c0;
      chk("match_gate", i[0] ? 32'h2 : 32'h6, c1);
    end
    wr(TGP_IDX_TIMER_CONTROL, 8'h00);
    $display("test gated count done");
    wr(TGP_IDX_GATE_CONTROL, 8'hd8);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, c0);
    pulse(20);
    rdc("go_done", TGP_IDX_GATE_CONTROL, 32'hd0);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, c1);
    chk("pulse_counted", 32'h1, {31'h0, c1[15:0] > c0[15:0]});
    pulse(20);
    rdc("pulse_ignored", TGP_IDX_GATED_COUNT, c1);
    wr(TGP_IDX_GATE_CONTROL, 8'hc8);
    rdc("go_forced", TGP_IDX_GATE_CONTROL, 32'hc0);
    wr(TGP_IDX_GATE_CONTROL, 8'hf8);
    pin_lvl <= 1'b1;
    repeat (10) @(posedge clk_sys);
    pin_lvl <= 1'b0;
    repeat (6) @(posedge clk_sys);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, c0);
    repeat (10) @(posedge clk_sys);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, c1);
    chk("cycle_counted", 32'h1, {31'h0, c1[15:0] > c0[15:0]});
    pulse(10);
    rdc("cycle_done", TGP_IDX_GATE_CONTROL, 32'hf0);
    bus(1'b0, TGP_IDX_GATED_COUNT, 8'h0, c0);
    pulse(10);
    rdc("cycle_ignored", TGP_IDX_GATED_COUNT, c0);
    $display("test single pulse done");
    tally_and_finish();
  end
endmodule
